// ### rtl/can_mode_pkg.sv
// package: register map, field layout, reset values and bus carriers of the mode control block
// Functional notes
// - sleep entered only when bus idle
// - sleep acknowledge flag set on sleep entry
// - sleep request refused while wakeup flag set
// - sleep held until cleared; wakeup clears request
// - sleep request clear ignored before sleep entered
// - init request aborts transfers, drops synchronization
// - init acknowledge flag set on init entry
// - init entry resets control and flag registers
// - init reset spares wakeup enable, both requests
// - init reset spares flag bits 3:2 (tx status) and enable bits 5:4
// - configuration registers writable only in init
// - error counters untouched by init mode
// - after init exit, resync on 11 recessive
// - bus-off exit waits 128 recessive runs
// - init request clear ignored before init entered
// - transmit pin recessive in stop, or in wait with CTL0_STOPW set
// - transmit pin recessive on init request
// - control one free in init; enable write-once outside special mode
// - bus activity in sleep clears sleep acknowledge if wakeup enabled
// - wakeup enable decides if traffic restarts
package can_mode_pkg;
    localparam int ADDR_W = 8;

    localparam logic [5:0] IDX_CTL0  = 6'h00;
    localparam logic [5:0] IDX_CTL1  = 6'h01;
    localparam logic [5:0] IDX_BTR0  = 6'h02;
    localparam logic [5:0] IDX_BTR1  = 6'h03;
    localparam logic [5:0] IDX_RFLG  = 6'h04;
    localparam logic [5:0] IDX_RIER  = 6'h05;
    localparam logic [5:0] IDX_TFLG  = 6'h06;
    localparam logic [5:0] IDX_TIER  = 6'h07;
    localparam logic [5:0] IDX_TARQ  = 6'h08;
    localparam logic [5:0] IDX_TAAK  = 6'h09;
    localparam logic [5:0] IDX_TBSEL = 6'h0a;
    localparam logic [5:0] IDX_IDAC  = 6'h0b;
    localparam logic [5:0] IDX_RXERR = 6'h0e;
    localparam logic [5:0] IDX_TXERR = 6'h0f;
    localparam logic [5:0] IDX_IDAR0 = 6'h10;
    localparam logic [5:0] IDX_IDMR0 = 6'h18;

    localparam int CTL0_RXFRM   = 7;
    localparam int CTL0_RXACT   = 6;
    localparam int CTL0_STOPW   = 5;
    localparam int CTL0_SYNCH   = 4;
    localparam int CTL0_WAKE_EN = 2;
    localparam int CTL0_SLP_RQ  = 1;
    localparam int CTL0_INIT_RQ = 0;
    localparam int CTL1_MOD_EN  = 7;
    localparam int CTL1_SLP_AK  = 1;
    localparam int CTL1_INIT_AK = 0;
    localparam int RFLG_WAKE_IF = 7;

    localparam logic [7:0] CTL0_RST   = 8'h00;
    localparam logic [7:0] CTL1_RST   = 8'h00;
    localparam logic [7:0] TFLG_RST   = 8'h07;
    localparam logic [7:0] ZERO_RST   = 8'h00;
    localparam logic [7:0] CTL0_WMASK = 8'h2c;
    localparam logic [7:0] CTL1_WMASK = 8'h7c;
    localparam logic [7:0] CTL0_KEEP  = 8'h07;
    localparam logic [7:0] RFLG_KEEP  = 8'h0c;
    localparam logic [7:0] RIER_KEEP  = 8'h30;
    localparam logic [7:0] RFLG_W1C   = 8'hc3;
    localparam logic [7:0] TFLG_W1C   = 8'h07;

    localparam int RECESSIVE_RUN = 11;
    localparam int BUSOFF_RUNS   = 128;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;
endpackage : can_mode_pkg

// ### rtl/bus_idle_counter.sv
// counter of recessive bit runs used to resynchronize after initialization
`timescale 1ns/10ps
module bus_idle_counter #(
    parameter int RUN_LEN = can_mode_pkg::RECESSIVE_RUN,
    parameter int RUNS    = can_mode_pkg::BUSOFF_RUNS
) (
    input  wire logic clk,      // module clock
    input  wire logic rst_n,    // synchronous reset, active low
    input  wire logic restart,  // hold cleared while high
    input  wire logic bit_tick, // one pulse per bit sample
    input  wire logic rx_bit,   // sampled bus level, 1 recessive
    input  wire logic bus_off,  // controller in bus-off
    output logic      done      // idle condition reached
);
    localparam int RW = $clog2(RUN_LEN + 1);
    localparam int NW = $clog2(RUNS + 1);

    if (RUN_LEN < 2 || RUNS < 1) begin : bad_param
        $error("bus_idle_counter: RUN_LEN must be >= 2 and RUNS >= 1");
    end

    typedef struct packed {
        logic [RW-1:0] run;
        logic [NW-1:0] runs;
        logic          boff;
        logic          done;
    } state_s;

    state_s q, d;

    always_comb begin
        d = q;
        if (restart) begin
            d = '0;
            d.boff = bus_off; // bus-off state at the moment of exit decides the wait
        end else if (bit_tick && !q.done) begin
            if (!rx_bit) begin
                d.run = '0;
            end else if (q.run == RW'(RUN_LEN - 1)) begin
                d.run = '0;
                if (!q.boff || q.runs == NW'(RUNS - 1)) begin
                    d.done = 1'b1;
                end else begin
                    d.runs = q.runs + NW'(1);
                end
            end else begin
                d.run = q.run + RW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;
endmodule : bus_idle_counter

// ### rtl/can_mode_control.sv
// mode control of the CAN controller: sleep and init handshakes, write locks, AXI4-Lite registers
`timescale 1ns/10ps
module can_mode_control #(
    parameter int RUN_LEN = can_mode_pkg::RECESSIVE_RUN,
    parameter int RUNS    = can_mode_pkg::BUSOFF_RUNS
) (
    input  wire logic                    CORE_CLK,     // module clock, 40 MHz
    input  wire logic                    RESET_N,      // synchronous reset, active low
    input  wire can_mode_pkg::axil_req_s S_AXI_REQ,    // AXI4-Lite master to slave
    output can_mode_pkg::axil_rsp_s      S_AXI_RSP,    // AXI4-Lite slave to master
    input  wire logic                    RX_PIN,       // bus level, 1 recessive
    input  wire logic                    BIT_TICK,     // bit sample pulse
    input  wire logic                    TX_BIT,       // bit from transmitter
    input  wire logic                    RX_ACTIVE,    // receiver busy
    input  wire logic                    TX_EMPTY,     // all transmit buffers empty
    input  wire logic                    RX_FRAME,     // valid frame received pulse
    input  wire logic                    BUS_OFF,      // bus-off state
    input  wire logic [3:0]              ERR_STATUS,   // rx hi, rx lo, tx hi, tx lo
    input  wire logic [7:0]              RX_ERR_CNT,   // receive error counter
    input  wire logic [7:0]              TX_ERR_CNT,   // transmit error counter
    input  wire logic                    CPU_WAIT,     // processor in wait
    input  wire logic                    CPU_STOP,     // processor in stop
    input  wire logic                    SPECIAL_MODE, // special system mode
    output logic                         BUS_TX_PIN,   // bus transmit level, 1 recessive
    output logic                         ABORT_XFER,   // abort transfers, level
    output logic                         SYNCHED,      // synchronized to bus
    output logic                         SLEEPING,     // sleep acknowledged
    output logic                         INIT_MODE,    // init acknowledged
    output logic [7:0]                   MODE_CTRL1    // control one contents
);
    typedef struct packed {
        logic [7:0]      ctl0;
        logic [7:0]      ctl1;
        logic [7:0]      btr0;
        logic [7:0]      btr1;
        logic [7:0]      rflg;
        logic [7:0]      rier;
        logic [7:0]      tflg;
        logic [7:0]      tier;
        logic [7:0]      tarq;
        logic [7:0]      taak;
        logic [7:0]      tbsel;
        logic [7:0]      idac;
        logic [7:0][7:0] idar;
        logic [7:0][7:0] idmr;
        logic            en_done;
        logic            synch;
        logic            abort;
        logic            tx_pin;
        logic            aw_got;
        logic            w_got;
        logic [5:0]      waddr;
        logic [7:0]      wdata;
        logic            wstrb0;
        can_mode_pkg::axil_rsp_s rsp;
    } state_s;

    state_s q, d;
    logic   idle_done;
    logic   wr_fire;
    logic   wr_en;
    logic   init_now;
    logic   in_init;
    logic   out_init;
    logic [7:0] wd;

    bus_idle_counter #(
        .RUN_LEN (RUN_LEN),
        .RUNS    (RUNS)
    ) u_idle (
        .clk      (CORE_CLK),
        .rst_n    (RESET_N),
        .restart  (q.ctl0[can_mode_pkg::CTL0_INIT_RQ] | q.ctl1[can_mode_pkg::CTL1_INIT_AK]),
        .bit_tick (BIT_TICK),
        .rx_bit   (RX_PIN),
        .bus_off  (BUS_OFF),
        .done     (idle_done)
    );

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx <= can_mode_pkg::IDX_IDAC) || (idx >= can_mode_pkg::IDX_RXERR && !idx[5]);
    endfunction : mapped

    function automatic logic [7:0] read_byte(input state_s s, input logic [5:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            can_mode_pkg::IDX_CTL0: begin
                v = s.ctl0;
                v[can_mode_pkg::CTL0_RXACT] = RX_ACTIVE;
                v[can_mode_pkg::CTL0_SYNCH] = s.synch;
            end
            can_mode_pkg::IDX_CTL1:  v = s.ctl1;
            can_mode_pkg::IDX_BTR0:  v = s.btr0;
            can_mode_pkg::IDX_BTR1:  v = s.btr1;
            can_mode_pkg::IDX_RFLG:  v = s.rflg;
            can_mode_pkg::IDX_RIER:  v = s.rier;
            can_mode_pkg::IDX_TFLG:  v = s.tflg;
            can_mode_pkg::IDX_TIER:  v = s.tier;
            can_mode_pkg::IDX_TARQ:  v = s.tarq;
            can_mode_pkg::IDX_TAAK:  v = s.taak;
            can_mode_pkg::IDX_TBSEL: v = s.tbsel;
            can_mode_pkg::IDX_IDAC:  v = s.idac;
            can_mode_pkg::IDX_RXERR: v = RX_ERR_CNT; // counters pass straight through
            can_mode_pkg::IDX_TXERR: v = TX_ERR_CNT;
            default: begin
                if (idx[5]) begin
                    v = 8'h00;
                end else if (idx >= can_mode_pkg::IDX_IDMR0) begin
                    v = s.idmr[idx[2:0]];
                end else if (idx >= can_mode_pkg::IDX_IDAR0) begin
                    v = s.idar[idx[2:0]];
                end
            end
        endcase
        read_byte = v;
    endfunction : read_byte

    always_comb begin
        d = q;
        // handshake bits live only in these flops, so reads always see settled values
        in_init  = q.ctl0[can_mode_pkg::CTL0_INIT_RQ] & q.ctl1[can_mode_pkg::CTL1_INIT_AK];
        out_init = ~q.ctl0[can_mode_pkg::CTL0_INIT_RQ] & ~q.ctl1[can_mode_pkg::CTL1_INIT_AK];
        wr_fire  = q.aw_got & q.w_got;
        // upper indices answer with an error and must not alias the mask registers
        wr_en    = wr_fire & q.wstrb0 & mapped(q.waddr);
        wd       = q.wdata;

        // write channel: address and data accepted in either order
        if (S_AXI_REQ.awvalid && q.rsp.awready) begin
            d.aw_got = 1'b1;
            d.waddr  = S_AXI_REQ.awaddr[can_mode_pkg::ADDR_W-1:2];
        end
        if (S_AXI_REQ.wvalid && q.rsp.wready) begin
            d.w_got  = 1'b1;
            d.wdata  = S_AXI_REQ.wdata[7:0];
            d.wstrb0 = S_AXI_REQ.wstrb[0];
        end
        if (q.rsp.bvalid && S_AXI_REQ.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_got       = 1'b0;
            d.w_got        = 1'b0;
            d.rsp.bvalid   = 1'b1;
            d.rsp.bresp    = mapped(q.waddr) ? can_mode_pkg::RESP_OKAY
                                             : can_mode_pkg::RESP_DECERR;
        end

        if (wr_en) begin
            case (q.waddr)
                can_mode_pkg::IDX_CTL0: begin
                    if (wd[can_mode_pkg::CTL0_INIT_RQ]) begin
                        d.ctl0[can_mode_pkg::CTL0_INIT_RQ] = 1'b1;
                    end else if (in_init) begin
                        d.ctl0[can_mode_pkg::CTL0_INIT_RQ] = 1'b0;
                    end
                    if (out_init) begin
                        d.ctl0 = (d.ctl0 & ~can_mode_pkg::CTL0_WMASK)
                               | (wd & can_mode_pkg::CTL0_WMASK);
                        if (wd[can_mode_pkg::CTL0_RXFRM]) begin
                            d.ctl0[can_mode_pkg::CTL0_RXFRM] = 1'b0;
                        end
                        if (wd[can_mode_pkg::CTL0_SLP_RQ]) begin
                            if (!q.rflg[can_mode_pkg::RFLG_WAKE_IF]) begin
                                d.ctl0[can_mode_pkg::CTL0_SLP_RQ] = 1'b1;
                            end
                        end else if (q.ctl1[can_mode_pkg::CTL1_SLP_AK]) begin
                            d.ctl0[can_mode_pkg::CTL0_SLP_RQ] = 1'b0;
                        end
                    end
                end
                can_mode_pkg::IDX_CTL1: begin
                    if (in_init) begin
                        d.ctl1 = (q.ctl1 & ~can_mode_pkg::CTL1_WMASK)
                               | (wd & can_mode_pkg::CTL1_WMASK);
                        if (SPECIAL_MODE || !q.en_done) begin
                            d.ctl1[can_mode_pkg::CTL1_MOD_EN] = wd[can_mode_pkg::CTL1_MOD_EN];
                            d.en_done = 1'b1;
                        end
                    end
                end
                can_mode_pkg::IDX_BTR0: if (in_init) d.btr0 = wd;
                can_mode_pkg::IDX_BTR1: if (in_init) d.btr1 = wd;
                can_mode_pkg::IDX_IDAC: if (in_init) d.idac = wd;
                can_mode_pkg::IDX_RFLG: begin
                    if (out_init) d.rflg = q.rflg & ~(wd & can_mode_pkg::RFLG_W1C);
                end
                can_mode_pkg::IDX_RIER:  if (out_init) d.rier = wd;
                can_mode_pkg::IDX_TFLG: begin
                    if (out_init) d.tflg = q.tflg & ~(wd & can_mode_pkg::TFLG_W1C);
                end
                can_mode_pkg::IDX_TIER:  if (out_init) d.tier = wd;
                can_mode_pkg::IDX_TARQ:  if (out_init) d.tarq = wd;
                can_mode_pkg::IDX_TBSEL: if (out_init) d.tbsel = wd;
                default: begin
                    if (in_init && q.waddr >= can_mode_pkg::IDX_IDMR0) begin
                        d.idmr[q.waddr[2:0]] = wd;
                    end else if (in_init && q.waddr >= can_mode_pkg::IDX_IDAR0) begin
                        d.idar[q.waddr[2:0]] = wd;
                    end
                end
            endcase
        end

        // hardware events after software, so a set in the clearing cycle wins
        if (RX_FRAME) begin
            d.ctl0[can_mode_pkg::CTL0_RXFRM] = 1'b1;
        end
        d.rflg[5:2] = ERR_STATUS;

        if (q.ctl0[can_mode_pkg::CTL0_SLP_RQ] && !q.ctl1[can_mode_pkg::CTL1_SLP_AK]
            && !RX_ACTIVE && TX_EMPTY) begin
            d.ctl1[can_mode_pkg::CTL1_SLP_AK] = 1'b1;
        end
        if (!d.ctl0[can_mode_pkg::CTL0_SLP_RQ]) begin
            d.ctl1[can_mode_pkg::CTL1_SLP_AK] = 1'b0;
        end
        // dominant level while asleep wakes only with wakeup enabled
        if (q.ctl1[can_mode_pkg::CTL1_SLP_AK] && q.ctl0[can_mode_pkg::CTL0_WAKE_EN]
            && !RX_PIN) begin
            d.ctl0[can_mode_pkg::CTL0_SLP_RQ]  = 1'b0;
            d.ctl1[can_mode_pkg::CTL1_SLP_AK]  = 1'b0;
            d.rflg[can_mode_pkg::RFLG_WAKE_IF] = 1'b1;
        end

        d.ctl1[can_mode_pkg::CTL1_INIT_AK] = q.ctl0[can_mode_pkg::CTL0_INIT_RQ];
        init_now = d.ctl0[can_mode_pkg::CTL0_INIT_RQ] & d.ctl1[can_mode_pkg::CTL1_INIT_AK];
        if (init_now) begin
            d.ctl0  = (can_mode_pkg::CTL0_RST & ~can_mode_pkg::CTL0_KEEP)
                    | (d.ctl0 & can_mode_pkg::CTL0_KEEP);
            d.rflg  = (can_mode_pkg::ZERO_RST & ~can_mode_pkg::RFLG_KEEP)
                    | (d.rflg & can_mode_pkg::RFLG_KEEP);
            d.rier  = (can_mode_pkg::ZERO_RST & ~can_mode_pkg::RIER_KEEP)
                    | (d.rier & can_mode_pkg::RIER_KEEP);
            d.tflg  = can_mode_pkg::TFLG_RST;
            d.tier  = can_mode_pkg::ZERO_RST;
            d.tarq  = can_mode_pkg::ZERO_RST;
            d.taak  = can_mode_pkg::ZERO_RST;
            d.tbsel = can_mode_pkg::ZERO_RST;
        end

        d.abort = d.ctl0[can_mode_pkg::CTL0_INIT_RQ];
        d.synch = ~d.ctl0[can_mode_pkg::CTL0_INIT_RQ] & ~d.ctl1[can_mode_pkg::CTL1_INIT_AK]
                & ~d.ctl1[can_mode_pkg::CTL1_SLP_AK] & idle_done;
        // pin is taken from next-state values so it goes recessive at the same edge
        if (d.ctl0[can_mode_pkg::CTL0_INIT_RQ]) begin
            d.tx_pin = 1'b1;
        end else if (CPU_STOP || (CPU_WAIT && d.ctl0[can_mode_pkg::CTL0_STOPW])) begin
            d.tx_pin = 1'b1;
        end else if (!d.synch || !d.ctl1[can_mode_pkg::CTL1_MOD_EN]) begin
            d.tx_pin = 1'b1;
        end else begin
            d.tx_pin = TX_BIT;
        end

        // read channel: one outstanding read
        if (q.rsp.rvalid && S_AXI_REQ.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (S_AXI_REQ.arvalid && q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata  = {24'h000000,
                            read_byte(q, S_AXI_REQ.araddr[can_mode_pkg::ADDR_W-1:2])};
            d.rsp.rresp  = mapped(S_AXI_REQ.araddr[can_mode_pkg::ADDR_W-1:2])
                         ? can_mode_pkg::RESP_OKAY : can_mode_pkg::RESP_DECERR;
        end
        d.rsp.arready = ~d.rsp.rvalid;
        d.rsp.awready = ~d.aw_got & ~d.rsp.bvalid;
        d.rsp.wready  = ~d.w_got & ~d.rsp.bvalid;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            q             <= '0;
            q.ctl0        <= can_mode_pkg::CTL0_RST;
            q.ctl1        <= can_mode_pkg::CTL1_RST;
            q.tflg        <= can_mode_pkg::TFLG_RST;
            q.tx_pin      <= 1'b1;
            q.rsp.awready <= 1'b1;
            q.rsp.wready  <= 1'b1;
            q.rsp.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign S_AXI_RSP  = q.rsp;
    assign BUS_TX_PIN = q.tx_pin;
    assign ABORT_XFER = q.abort;
    assign SYNCHED    = q.synch;
    assign SLEEPING   = q.ctl1[can_mode_pkg::CTL1_SLP_AK];
    assign INIT_MODE  = q.ctl1[can_mode_pkg::CTL1_INIT_AK];
    assign MODE_CTRL1 = q.ctl1;
endmodule : can_mode_control

// ### bench/can_bus_model.sv
// partner model: bus level and bit sample pulses seen by the node
`timescale 1ns/10ps
module can_bus_model #(
    parameter int BIT_CYC = 4 // cycles per bit
) (
    input  wire logic clk,  // module clock
    input  wire logic dom,  // some node drives dominant
    output logic      tick, // bit sample pulse
    output logic      rx    // wired-and level, 1 recessive
);
    int cnt = 0;
    initial begin
        tick = 1'b0;
        rx   = 1'b1;
    end
    // level moves only on bit boundaries; a released bus floats recessive
    always @(posedge clk) begin
        cnt  <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
        tick <= (cnt == BIT_CYC - 1);
        rx   <= (cnt == BIT_CYC - 1) ? !dom : rx;
    end
endmodule : can_bus_model

// ### bench/can_mode_control_assertions.sv
// concurrent checks on the mode control ports
`timescale 1ns/10ps
module can_mode_control_assertions #(
    parameter int RUN_LEN = 11,
    parameter int RUNS    = 128
) (
    input wire logic       CORE_CLK,   // module clock
    input wire logic       RESET_N,    // reset, active low
    input wire logic       RX_PIN,     // bus level
    input wire logic       BIT_TICK,   // bit sample pulse
    input wire logic       RX_ACTIVE,  // receiver busy
    input wire logic       TX_EMPTY,   // tx buffers empty
    input wire logic       CPU_STOP,   // processor stop
    input wire logic       BUS_TX_PIN, // tx level
    input wire logic       ABORT_XFER, // init request
    input wire logic       SYNCHED,    // synchronized
    input wire logic       SLEEPING,   // sleep ack
    input wire logic       INIT_MODE,  // init ack
    input wire logic [7:0] MODE_CTRL1  // control one
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    // counts one tick more than the design may, so the bound stays safe
    logic [15:0] run_q;
    wire  [15:0] run_d = (ABORT_XFER || (BIT_TICK && !RX_PIN)) ? 16'h0000 : run_q + 16'(BIT_TICK);
    always_ff @(posedge CORE_CLK) begin
        run_q <= RESET_N ? run_d : 16'h0000;
    end
    a_init_ack_follow: assert property (ABORT_XFER |=> INIT_MODE) else $error("init ack");
    a_init_clear_order: assert property ($fell(ABORT_XFER) |-> $past(INIT_MODE))
        else $error("init clear early");
    a_tx_on_init: assert property (ABORT_XFER |-> BUS_TX_PIN) else $error("tx in init");
    a_unsync_init: assert property (ABORT_XFER |-> !SYNCHED) else $error("sync in init");
    a_tx_on_stop: assert property (CPU_STOP |=> BUS_TX_PIN) else $error("tx in stop");
    a_sleep_idle: assert property ($rose(SLEEPING) |-> !$past(RX_ACTIVE) && $past(TX_EMPTY))
        else $error("sleep while busy");
    a_ctl1_locked: assert property ($changed(MODE_CTRL1[7:2]) |-> $past(INIT_MODE))
        else $error("control one written outside init");
    a_ack_mirror: assert property (INIT_MODE == $past(ABORT_XFER)
        && MODE_CTRL1[1:0] == {SLEEPING, INIT_MODE}) else $error("ack bits differ");
    // leaving sleep resumes the earlier lock, so only exits from init are timed
    a_sync_run: assert property ($rose(SYNCHED) && !$past(SLEEPING)
        |-> run_q >= RUN_LEN) else $error("sync too early");
    c_synch: cover property ($rose(SYNCHED));
    c_wake: cover property ($fell(SLEEPING) && !RX_PIN);
    c_init: cover property ($rose(INIT_MODE));
endmodule : can_mode_control_assertions
bind can_mode_control can_mode_control_assertions #(.RUN_LEN(RUN_LEN), .RUNS(RUNS)) chk_i (
    .CORE_CLK, .RESET_N, .RX_PIN, .BIT_TICK, .RX_ACTIVE, .TX_EMPTY, .CPU_STOP,
    .BUS_TX_PIN, .ABORT_XFER, .SYNCHED, .SLEEPING, .INIT_MODE, .MODE_CTRL1);

// ### bench/tb_can_mode_control.sv
// self-checking bench of the mode control block
`timescale 1ns/10ps
module tb_can_mode_control;
    localparam int RL = 11;
    localparam int RN = 2;
    localparam int BP = 4;
    localparam int SYN = 2, SLP = 1, INI = 0;
    can_mode_pkg::axil_req_s req = '0;
    can_mode_pkg::axil_rsp_s rsp;
    logic clk = 1'b0, rst_n = 1'b0, dom = 1'b0, tx_bit = 1'b1, rx_act = 1'b0;
    logic tx_empty = 1'b0, bus_off = 1'b0, cpu_stop = 1'b0, cpu_wait = 1'b0, special = 1'b0;
    logic txp, abt, syn, slp, ini, tick, rx;
    logic [3:0] err_st = 4'h0;
    logic [7:0] rxe = 8'h00, txe = 8'h00, d;
    logic [1:0] resp;
    int seed = 32'hcff557eb;
    int bad_count = 0, n_tests = 0, cyc = 0, w = 0, n;
    wire [2:0] st = {syn, slp, ini};
    can_bus_model #(.BIT_CYC(BP)) can_bus_model_i (.clk(clk), .dom(dom), .tick(tick), .rx(rx));
    can_mode_control #(.RUN_LEN(RL), .RUNS(RN)) can_mode_control_i (
        .CORE_CLK(clk), .RESET_N(rst_n), .S_AXI_REQ(req), .S_AXI_RSP(rsp), .RX_PIN(rx),
        .BIT_TICK(tick), .TX_BIT(tx_bit), .RX_ACTIVE(rx_act), .TX_EMPTY(tx_empty),
        .RX_FRAME(1'b0), .BUS_OFF(bus_off), .ERR_STATUS(err_st), .RX_ERR_CNT(rxe),
        .TX_ERR_CNT(txe), .CPU_WAIT(cpu_wait), .CPU_STOP(cpu_stop), .SPECIAL_MODE(special),
        .BUS_TX_PIN(txp), .ABORT_XFER(abt), .SYNCHED(syn), .SLEEPING(slp), .INIT_MODE(ini),
        .MODE_CTRL1());
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h000000, v};
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask : wr
    // the synchronized bit of control zero is masked; the ports cover it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        resp = rsp.rresp;
        req.rready <= 1'b0;
        chk(rsp.rdata & {24'hffffff, (a == 8'h00) ? 8'hef : 8'hff}, {24'h000000, e});
    endtask : rd
    task automatic wt(input int k, input logic v);
        w = 0;
        while (st[k] !== v && w < 3000) begin
            @(posedge clk);
            w++;
        end
        chk(st[k], v);
    endtask : wt
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h18, 8'h07);
        rd(8'h30, 8'h00);
        chk(resp, can_mode_pkg::RESP_DECERR);
        d = 8'($random(seed));
        wr(8'h04, d);
        rd(8'h04, 8'h00);
        wr(8'h40, d);
        rd(8'h40, 8'h00);
        $display("test reset and locks done");
        rx_act   <= 1'b1;
        tx_empty <= 1'b1;
        wr(8'h00, 8'h06);
        repeat (20) @(posedge clk);
        chk(slp, 1'b0);
        rx_act <= 1'b0;
        wt(SLP, 1'b1);
        wr(8'h00, 8'h04);
        wt(SLP, 1'b0);
        tx_empty <= 1'b0;
        wr(8'h00, 8'h06);
        wr(8'h00, 8'h04);
        rd(8'h00, 8'h06);
        tx_empty <= 1'b1;
        wt(SLP, 1'b1);
        dom <= 1'b1;
        wt(SLP, 1'b0);
        dom <= 1'b0;
        rd(8'h00, 8'h04);
        rd(8'h10, 8'h80);
        wr(8'h00, 8'h06);
        rd(8'h00, 8'h04);
        wr(8'h10, 8'h80);
        rd(8'h10, 8'h00);
        wr(8'h00, 8'h02);
        wt(SLP, 1'b1);
        dom <= 1'b1;
        repeat (12) @(posedge clk);
        chk(slp, 1'b1);
        dom <= 1'b0;
        $display("test sleep and wake done");
        for (int bo = 0; bo < 2; bo++) begin
            n = bo ? RN : 1;
            bus_off <= bo[0];
            err_st  <= {2'b00, 2'($random(seed))};
            rxe     <= 8'($random(seed));
            txe     <= 8'($random(seed));
            wr(8'h00, 8'h05);
            wt(INI, 1'b1);
            chk({txp, abt, syn}, 3'b110);
            rd(8'h00, 8'h05);
            rd(8'h10, {4'h0, err_st[1:0], 2'b00});
            rd(8'h38, rxe);
            rd(8'h3c, txe);
            d = 8'($random(seed));
            // normal mode keeps the first enable value, special mode takes every write
            d[7] = (bo == 0);
            special <= bo[0];
            wr(8'h04, d);
            rd(8'h04, (d & 8'hfc) | 8'h01);
            d[7] = bo[0];
            wr(8'h04, d);
            rd(8'h04, (d & 8'h7c) | 8'h81);
            wr(8'h00, 8'h04);
            wt(INI, 1'b0);
            wt(SYN, 1'b1);
            chk(w >= (n * RL - 2) * BP && w <= (n * RL + 2) * BP, 1'b1);
            tx_bit <= 1'b0;
            repeat (3) @(posedge clk);
            chk(txp, 1'b0);
        end
        wr(8'h14, 8'h80);
        rd(8'h14, 8'h80);
        cpu_stop <= 1'b1;
        repeat (2) @(posedge clk);
        chk(txp, 1'b1);
        cpu_stop <= 1'b0;
        cpu_wait <= 1'b1;
        repeat (3) @(posedge clk);
        chk(txp, 1'b0);
        wr(8'h00, 8'h24);
        repeat (2) @(posedge clk);
        chk(txp, 1'b1);
        $display("test init and resync done");
        stop_test();
    end
endmodule : tb_can_mode_control
